// ==== logic/synth_cfg_pkg.sv ====
// shared constants and types for the divider configuration port
package synth_cfg_pkg;
    localparam int LOOP_W  = 9;
    localparam int ODIV_W  = 2;
    localparam int TEST_W  = 3;
    localparam int SHIFT_W = 14;
    localparam int NMOD_W  = 4;

    // shift register field layout, test bits enter first
    localparam int SH_TEST_MSB = 13;
    localparam int SH_TEST_LSB = 11;
    localparam int SH_ODIV_MSB = 10;
    localparam int SH_ODIV_LSB = 9;
    localparam int SH_LOOP_MSB = 8;
    localparam int SH_LOOP_LSB = 0;

    // reference predivide ahead of the phase detector
    localparam int          REF_PREDIV   = 8;
    localparam logic [2:0]  REF_HALF_CNT = 3'h3;

    typedef struct packed {
        logic [TEST_W-1:0] test;
        logic [ODIV_W-1:0] odiv;
        logic [LOOP_W-1:0] loop;
    } cfg_t;

    // pins are pulled up, so an idle parallel bus reads all ones
    localparam cfg_t CFG_RESET = '{test: 3'h0, odiv: 2'h3, loop: 9'h1FF};

    // output divider select codes and their moduli
    localparam logic [ODIV_W-1:0] ODIV_SEL_2 = 2'h0;
    localparam logic [ODIV_W-1:0] ODIV_SEL_4 = 2'h1;
    localparam logic [ODIV_W-1:0] ODIV_SEL_8 = 2'h2;
    localparam logic [ODIV_W-1:0] ODIV_SEL_1 = 2'h3;
    localparam logic [NMOD_W-1:0] NMOD_1     = 4'h1;
    localparam logic [NMOD_W-1:0] NMOD_2     = 4'h2;
    localparam logic [NMOD_W-1:0] NMOD_4     = 4'h4;
    localparam logic [NMOD_W-1:0] NMOD_8     = 4'h8;

    // probe selection codes
    localparam logic [TEST_W-1:0] TEST_SHIFT  = 3'h0;
    localparam logic [TEST_W-1:0] TEST_HIGH   = 3'h1;
    localparam logic [TEST_W-1:0] TEST_REF    = 3'h2;
    localparam logic [TEST_W-1:0] TEST_LOOP   = 3'h3;
    localparam logic [TEST_W-1:0] TEST_SYNTH  = 3'h4;
    localparam logic [TEST_W-1:0] TEST_LOW    = 3'h5;
    localparam logic [TEST_W-1:0] TEST_BYPASS = 3'h6;
    localparam logic [TEST_W-1:0] TEST_QUART  = 3'h7;

    // register map, byte addresses
    localparam logic [7:0]  REG_STATUS = 8'h00;
    localparam logic [7:0]  REG_SHIFT  = 8'h04;
    localparam logic [7:0]  REG_CTRL   = 8'h08;
    localparam int          CTRL_RUN   = 0;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
    localparam int          ST_LOOP_LSB = 0;
    localparam int          ST_ODIV_LSB = 16;
    localparam int          ST_TEST_LSB = 20;
    localparam int          ST_PAR_BIT  = 24;
    localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
    localparam logic        HRESP_OKAY    = 1'h0;
endpackage : synth_cfg_pkg

// ==== logic/sync2.sv ====
// two-flop synchroniser for pin inputs
`timescale 1ns/10ps
module sync2 #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         hclk,
    input  wire logic         hresetn,
    input  wire logic         ce,
    // data
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] stage1;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stage1   <= '0;
            sync_out <= '0;
        end else if (ce) begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end
endmodule : sync2

// ==== logic/mod_counter.sv ====
// modulus counter: one-cycle wrap pulse every modulus ticks
`timescale 1ns/10ps
module mod_counter #(
    parameter int W = 9
) (
    // clock and reset
    input  wire logic         hclk,
    input  wire logic         hresetn,
    input  wire logic         ce,
    // control
    input  wire logic         clear,
    input  wire logic         tick,
    input  wire logic [W-1:0] modulus,
    // result
    output logic              wrap
);
    logic [W-1:0] count;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count <= '0;
            wrap  <= 1'b0;
        end else if (ce) begin
            wrap <= 1'b0;
            if (clear) begin
                count <= '0;
            end else if (tick) begin
                // a new modulus takes effect at once, even below count
                if (count >= modulus - W'(1)) begin
                    count <= '0;
                    wrap  <= 1'b1;
                end else begin
                    count <= count + W'(1);
                end
            end
        end
    end
endmodule : mod_counter

// ==== logic/synth_divider_config_port.sv ====
// divider configuration, dividers and probe mux of the clock synthesizer
//
// How it works
// - output is reference over 8, times M, over N
// - loop field unsigned, bit 8 MSB; 01 is /4
// - parallel strobe rise captures M and N pins
// - parallel latches transparent while strobe low
// - serial data sampled into 14-bit shift register
// - one shift per shift clock rising edge
// - serial load works only with strobe high
// - stream order: test, output divider, loop
// - each field shifted in MSB first
// - serial strobe falling edge commits shifted values
// - serial latches transparent while serial strobe high
// - parallel load beats serial load
// - test bits cleared while parallel strobe low
// - parallel path writes test bits only to clear them
// - probe mux per test code table
// - test reset shows shift register serial output
// - code 110 bypass: shift clock drives dividers
// - loop counter probe output not 50% duty
`timescale 1ns/10ps
module synth_divider_config_port #(
    parameter int LOOP_W = synth_cfg_pkg::LOOP_W,
    parameter int NMOD_W = synth_cfg_pkg::NMOD_W
) (
    // clock, reset, enable
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire logic              ce,
    // ahb-lite slave
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic      [31:0]       hrdata,
    output logic                   hreadyout,
    output logic                   hresp,
    // parallel load pins
    input  wire logic              parallel_commit_n,
    input  wire logic [LOOP_W-1:0] loop_pins,
    input  wire logic [1:0]        odiv_pins,
    // serial load pins
    input  wire logic              shift_clock_alt,
    input  wire logic              shift_data,
    input  wire logic              serial_commit,
    // clock sources
    input  wire logic              vco_in,
    input  wire logic              phase_ref,
    // outputs
    output logic                   synth_out,
    output logic                   synth_out_n,
    output logic                   loop_counter_out,
    output logic                   ref_div8,
    output logic                   probe_out
);
    // six control pins, the loop pins and the high select bit share one synchroniser
    localparam int SYNC_W = 7 + LOOP_W;

    synth_cfg_pkg::cfg_t                   cfg;
    logic [synth_cfg_pkg::SHIFT_W-1:0]     shreg;
    logic [SYNC_W-1:0]                     sync_raw;
    logic [SYNC_W-1:0]                     sync_q;
    logic                                  pcommit_n_s;
    logic                                  sclk_s;
    logic                                  sdata_s;
    logic                                  scommit_s;
    logic                                  vco_s;
    logic                                  ref_s;
    logic [LOOP_W-1:0]                     loop_s;
    logic [1:0]                            odiv_s;
    logic                                  sclk_d;
    logic                                  src_d;
    logic                                  ref_d;
    logic                                  src;
    logic                                  src_rise;
    logic                                  src_edge;
    logic                                  sclk_rise;
    logic [NMOD_W-1:0]                     nmod;
    logic                                  loop_wrap;
    logic                                  odiv_wrap;
    logic [1:0]                            quart_cnt;
    logic                                  synth_d;
    logic [2:0]                            ref_cnt;
    logic [31:0]                           ctrl;
    logic                                  run;
    logic                                  dph_write;
    logic [7:0]                            dph_addr;
    logic                                  addr_ok;
    logic                                  next_probe;
    logic [31:0]                           next_rdata;

    // pins come from outside the clock domain: two flops each
    assign sync_raw = {parallel_commit_n, shift_clock_alt, shift_data, serial_commit,
                       vco_in, phase_ref, loop_pins, odiv_pins[1]};
    sync2 #(.W(SYNC_W)) u_sync (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .ce       (ce),
        .async_in (sync_raw),
        .sync_out (sync_q)
    );
    assign {pcommit_n_s, sclk_s, sdata_s, scommit_s, vco_s, ref_s, loop_s} =
        sync_q[SYNC_W-1:1];

    // low bit of the output divider pins synchronised apart to keep the bundle tidy
    sync2 #(.W(1)) u_sync_n0 (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .ce       (ce),
        .async_in (odiv_pins[0]),
        .sync_out (odiv_s[0])
    );
    assign odiv_s[1] = sync_q[0];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sclk_d <= 1'b0;
            src_d  <= 1'b0;
            ref_d  <= 1'b0;
        end else if (ce) begin
            sclk_d <= sclk_s;
            src_d  <= src;
            ref_d  <= ref_s;
        end
    end
    assign sclk_rise = sclk_s & ~sclk_d;

    // shift register keeps running with the strobe low so the probe can stream it out
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            shreg <= '0;
        end else if (ce && sclk_rise) begin
            shreg <= {shreg[synth_cfg_pkg::SHIFT_W-2:0], sdata_s};
        end
    end

    // configuration latches, modelled as level-sensitive registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg <= synth_cfg_pkg::CFG_RESET;
        end else if (ce) begin
            if (!pcommit_n_s) begin
                cfg.loop <= loop_s;
                cfg.odiv <= odiv_s;
                cfg.test <= synth_cfg_pkg::TEST_SHIFT;
            end else if (scommit_s) begin
                // transparent while high, so the last value at the fall sticks
                cfg.test <= shreg[synth_cfg_pkg::SH_TEST_MSB:synth_cfg_pkg::SH_TEST_LSB];
                cfg.odiv <= shreg[synth_cfg_pkg::SH_ODIV_MSB:synth_cfg_pkg::SH_ODIV_LSB];
                cfg.loop <= shreg[synth_cfg_pkg::SH_LOOP_MSB:synth_cfg_pkg::SH_LOOP_LSB];
            end
        end
    end

    always_comb begin
        unique case (cfg.odiv)
            synth_cfg_pkg::ODIV_SEL_4: nmod = synth_cfg_pkg::NMOD_4;
            synth_cfg_pkg::ODIV_SEL_2: nmod = synth_cfg_pkg::NMOD_2;
            synth_cfg_pkg::ODIV_SEL_8: nmod = synth_cfg_pkg::NMOD_8;
            synth_cfg_pkg::ODIV_SEL_1: nmod = synth_cfg_pkg::NMOD_1;
        endcase
    end

    // divider source: the vco, or the shift clock in bypass
    assign src      = (cfg.test == synth_cfg_pkg::TEST_BYPASS) ? sclk_s : vco_s;
    assign src_rise = src & ~src_d;
    // output divider counts both edges so any modulus, even 1, keeps 50% duty
    assign src_edge = src ^ src_d;
    assign run      = ctrl[synth_cfg_pkg::CTRL_RUN];

    mod_counter #(.W(LOOP_W)) u_loop_div (
        .hclk    (hclk),
        .hresetn (hresetn),
        .ce      (ce),
        .clear   (~run),
        .tick    (src_rise),
        .modulus (cfg.loop),
        .wrap    (loop_wrap)
    );

    mod_counter #(.W(NMOD_W)) u_out_div (
        .hclk    (hclk),
        .hresetn (hresetn),
        .ce      (ce),
        .clear   (~run),
        .tick    (src_edge),
        .modulus (nmod),
        .wrap    (odiv_wrap)
    );

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            synth_out        <= 1'b0;
            synth_out_n      <= 1'b1;
            loop_counter_out <= 1'b0;
            synth_d          <= 1'b0;
            quart_cnt        <= '0;
        end else if (ce) begin
            if (odiv_wrap) begin
                synth_out   <= ~synth_out;
                synth_out_n <= synth_out;
            end
            // one-cycle pulse per wrap: short high, not a square wave
            loop_counter_out <= loop_wrap;
            synth_d          <= synth_out;
            if (synth_out && !synth_d) begin
                quart_cnt <= quart_cnt + 2'h1;
            end
        end
    end

    // reference predivide feeding the phase detector
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ref_cnt  <= '0;
            ref_div8 <= 1'b0;
        end else if (ce && ref_s && !ref_d) begin
            if (ref_cnt == synth_cfg_pkg::REF_HALF_CNT) begin
                ref_cnt  <= '0;
                ref_div8 <= ~ref_div8;
            end else begin
                ref_cnt <= ref_cnt + 3'h1;
            end
        end
    end

    always_comb begin
        unique case (cfg.test)
            synth_cfg_pkg::TEST_SHIFT:  next_probe = shreg[synth_cfg_pkg::SHIFT_W-1];
            synth_cfg_pkg::TEST_HIGH:   next_probe = 1'b1;
            synth_cfg_pkg::TEST_REF:    next_probe = ref_s;
            synth_cfg_pkg::TEST_LOOP:   next_probe = loop_wrap;
            synth_cfg_pkg::TEST_SYNTH:  next_probe = odiv_wrap ^ synth_out;
            synth_cfg_pkg::TEST_LOW:    next_probe = 1'b0;
            synth_cfg_pkg::TEST_BYPASS: next_probe = loop_wrap;
            synth_cfg_pkg::TEST_QUART:  next_probe = quart_cnt[1];
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            probe_out <= 1'b0;
        end else if (ce) begin
            probe_out <= next_probe;
        end
    end

    // ahb-lite slave, zero wait states, always OKAY
    assign addr_ok = hsel && hready && (htrans == synth_cfg_pkg::HTRANS_NONSEQ);

    always_comb begin
        next_rdata = '0;
        unique case (haddr[7:0])
            synth_cfg_pkg::REG_STATUS: begin
                next_rdata[synth_cfg_pkg::ST_LOOP_LSB +: LOOP_W] = cfg.loop;
                next_rdata[synth_cfg_pkg::ST_ODIV_LSB +: 2]      = cfg.odiv;
                next_rdata[synth_cfg_pkg::ST_TEST_LSB +: 3]      = cfg.test;
                next_rdata[synth_cfg_pkg::ST_PAR_BIT]            = pcommit_n_s;
            end
            synth_cfg_pkg::REG_SHIFT:
                next_rdata[synth_cfg_pkg::SHIFT_W-1:0] = shreg;
            synth_cfg_pkg::REG_CTRL:
                next_rdata = ctrl;
            default:
                next_rdata = '0;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dph_write <= 1'b0;
            dph_addr  <= '0;
            hrdata    <= '0;
            hreadyout <= 1'b1;
            hresp     <= synth_cfg_pkg::HRESP_OKAY;
        end else if (ce) begin
            dph_write <= addr_ok && hwrite;
            dph_addr  <= haddr[7:0];
            hreadyout <= 1'b1;
            hresp     <= synth_cfg_pkg::HRESP_OKAY;
            if (addr_ok && !hwrite) begin
                hrdata <= next_rdata;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl <= synth_cfg_pkg::CTRL_RESET;
        end else if (ce && dph_write && dph_addr == synth_cfg_pkg::REG_CTRL) begin
            ctrl <= {31'h0000_0000, hwdata[synth_cfg_pkg::CTRL_RUN]};
        end
    end

    property p_par_load;
        @(posedge hclk) disable iff (!hresetn)
        (ce && !pcommit_n_s) |=> (cfg.loop == $past(loop_s) && cfg.odiv == $past(odiv_s));
    endproperty
    a_par_load: assert property (p_par_load) else $error("parallel load missed");

    property p_test_clear;
        @(posedge hclk) disable iff (!hresetn)
        (ce && !pcommit_n_s) |=> cfg.test == synth_cfg_pkg::TEST_SHIFT;
    endproperty
    a_test_clear: assert property (p_test_clear) else $error("test bits not cleared");

    property p_ser_load;
        @(posedge hclk) disable iff (!hresetn)
        (ce && pcommit_n_s && scommit_s) |=> cfg == $past(shreg);
    endproperty
    a_ser_load: assert property (p_ser_load) else $error("serial commit wrong");

    property p_ser_hold;
        @(posedge hclk) disable iff (!hresetn)
        (ce && pcommit_n_s && !scommit_s) |=> $stable(cfg);
    endproperty
    a_ser_hold: assert property (p_ser_hold) else $error("config changed idle");

    property p_shift;
        @(posedge hclk) disable iff (!hresetn)
        (ce && sclk_rise) |=> shreg == {$past(shreg[12:0]), $past(sdata_s)};
    endproperty
    a_shift: assert property (p_shift) else $error("shift register wrong");

    property p_no_shift;
        @(posedge hclk) disable iff (!hresetn)
        (ce && !sclk_rise) |=> $stable(shreg);
    endproperty
    a_no_shift: assert property (p_no_shift) else $error("extra shift");

    property p_probe_shift;
        @(posedge hclk) disable iff (!hresetn)
        (ce && cfg.test == synth_cfg_pkg::TEST_SHIFT) |=> probe_out == $past(shreg[13]);
    endproperty
    a_probe_shift: assert property (p_probe_shift) else $error("probe not shift out");

    property p_bypass;
        @(posedge hclk) disable iff (!hresetn)
        (ce && cfg.test == synth_cfg_pkg::TEST_BYPASS &&
            $past(cfg.test) == synth_cfg_pkg::TEST_BYPASS) |-> src_rise == sclk_rise ##1
            (!ce || probe_out == loop_counter_out);
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass routing wrong");

    property p_div4;
        @(posedge hclk) disable iff (!hresetn)
        cfg.odiv == synth_cfg_pkg::ODIV_SEL_4 |-> nmod == synth_cfg_pkg::NMOD_4;
    endproperty
    a_div4: assert property (p_div4) else $error("select 01 not divide by 4");

    property p_pair;
        @(posedge hclk) disable iff (!hresetn)
        synth_out_n == ~synth_out;
    endproperty
    a_pair: assert property (p_pair) else $error("output pair not complementary");
endmodule : synth_divider_config_port

// ==== verif/cfg_host_model.sv ====
// host-side driver of the parallel and serial configuration pins
`timescale 1ns/10ps
module cfg_host_model (
    // clock
    input  wire logic       hclk,
    // parallel pins
    output logic            parallel_commit_n,
    output logic [8:0]      loop_pins,
    output logic [1:0]      odiv_pins,
    // serial pins
    output logic            shift_clock_alt,
    output logic            shift_data,
    output logic            serial_commit
);
    // power-up: strobe low, divider pins at their pulled-up level
    initial begin
        parallel_commit_n = 1'b0;
        loop_pins         = 9'h1FF;
        odiv_pins         = 2'h3;
        shift_clock_alt   = 1'b0;
        shift_data        = 1'b0;
        serial_commit     = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge hclk);
    endtask : tick
    // caller keeps the loop modulus in the lockable range
    task automatic par_set(input logic [8:0] m, input logic [1:0] n);
        parallel_commit_n <= 1'b0;
        loop_pins         <= m;
        odiv_pins         <= n;
        tick(4);
    endtask : par_set
    task automatic par_commit();
        parallel_commit_n <= 1'b1;
        tick(4);
        // pins wander after capture, so a leaky latch shows up
        loop_pins <= ~loop_pins;
        odiv_pins <= ~odiv_pins;
        tick(4);
    endtask : par_commit
    // msb first: test, output divider, loop; parallel strobe stays high
    task automatic ser_load(input logic [13:0] word);
        for (int i = 13; i >= 0; i--) begin
            shift_data      <= word[i];
            tick(4);
            shift_clock_alt <= 1'b1;
            tick(4);
            shift_clock_alt <= 1'b0;
        end
        // released data line settles at its pull-down level
        shift_data <= 1'b0;
        tick(4);
    endtask : ser_load
    task automatic ser_commit();
        serial_commit <= 1'b1;
        tick(6);
        serial_commit <= 1'b0;
        tick(4);
    endtask : ser_commit
endmodule : cfg_host_model

// ==== verif/synth_divider_config_port_bench.sv ====
// self-checking bench for the divider configuration port
`timescale 1ns/10ps
module synth_divider_config_port_bench;
    logic        hclk = 1'b0, hresetn = 1'b0, vco_in = 1'b0, phase_ref = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic        hwrite = 1'b0, hreadyout, hresp;
    logic        parallel_commit_n, shift_clock_alt, shift_data, serial_commit;
    logic [8:0]  loop_pins;
    logic [1:0]  odiv_pins;
    logic        synth_out, synth_out_n, loop_counter_out, probe_out, ref_div8;
    logic        ce = 1'b1;
    int          err_total = 0, checks_done = 0, n_synth = 0, n_loop = 0;
    int          n_ref = 0, n_probe = 0;
    int          e_loop, e_odiv, e_test, e_par;

    always #5 hclk = ~hclk;
    always #40 vco_in = ~vco_in;
    always #35 phase_ref = ~phase_ref;
    always @(posedge synth_out) n_synth++;
    always @(posedge loop_counter_out) n_loop++;
    always @(posedge ref_div8) n_ref++;
    always @(posedge probe_out) n_probe++;

    synth_divider_config_port DUT (
        .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(1'b1), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .parallel_commit_n(parallel_commit_n), .loop_pins(loop_pins),
        .odiv_pins(odiv_pins), .shift_clock_alt(shift_clock_alt),
        .shift_data(shift_data), .serial_commit(serial_commit), .vco_in(vco_in),
        .phase_ref(phase_ref), .synth_out(synth_out), .synth_out_n(synth_out_n),
        .loop_counter_out(loop_counter_out), .ref_div8(ref_div8), .probe_out(probe_out));

    cfg_host_model host (
        .hclk(hclk), .parallel_commit_n(parallel_commit_n), .loop_pins(loop_pins),
        .odiv_pins(odiv_pins), .shift_clock_alt(shift_clock_alt),
        .shift_data(shift_data), .serial_commit(serial_commit));

    task automatic tally_and_finish();
        $display("mismatches %0d, comparisons %0d", err_total, checks_done);
        if (err_total == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // edge counts are taken over a window, so one edge of slack
    task automatic chk_near(input int got, input int exp);
        chk({31'h0, got >= exp - 1 && got <= exp + 1}, 32'h1);
    endtask : chk_near
    task automatic wait_rdy();
        int i;
        for (i = 0; i < 20 && hreadyout !== 1'b1; i++) @(posedge hclk);
        if (i == 20) begin
            err_total++;
            $display("Error at %0t: bus wait ran out", $time);
            tally_and_finish();
        end
    endtask : wait_rdy
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        htrans <= synth_cfg_pkg::HTRANS_NONSEQ;
        haddr  <= {24'h0, a};
        hwrite <= wr;
        @(posedge hclk);
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        wait_rdy();
        rd = hrdata;
        chk({31'h0, hresp}, {31'h0, synth_cfg_pkg::HRESP_OKAY});
    endtask : ahb
    task automatic chk_status();
        ahb(1'b0, synth_cfg_pkg::REG_STATUS, 32'h0);
        chk(rd, (e_par << synth_cfg_pkg::ST_PAR_BIT) | (e_test << synth_cfg_pkg::ST_TEST_LSB)
            | (e_odiv << synth_cfg_pkg::ST_ODIV_LSB) | e_loop);
    endtask : chk_status

    initial begin
        int m, n;
        logic [13:0] w;
        void'($urandom(32'hCADD0146));
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (4) @(posedge hclk);
        {e_loop, e_odiv, e_test, e_par} = {32'h1FF, 32'h3, 32'h0, 32'h0};
        chk_status();
        ahb(1'b0, synth_cfg_pkg::REG_CTRL, 32'h0);
        chk(rd, synth_cfg_pkg::CTRL_RESET);
        ahb(1'b1, 8'h0C, 32'hFFFFFFFF);
        ahb(1'b0, 8'h0C, 32'h0);
        chk(rd, 32'h0);
        for (int k = 0; k < 2; k++) begin
            m = 200 + $urandom_range(200);
            n = $urandom_range(3);
            host.par_set(m[8:0], n[1:0]);
            {e_loop, e_odiv} = {m, n};
            chk_status();
        end
        host.par_commit();
        e_par = 1;
        chk_status();
        for (int k = 0; k < 2; k++) begin
            m = 200 + $urandom_range(200);
            n = $urandom_range(3);
            w = {k ? synth_cfg_pkg::TEST_LOW : synth_cfg_pkg::TEST_HIGH, n[1:0], m[8:0]};
            host.ser_load(w);
            ahb(1'b0, synth_cfg_pkg::REG_SHIFT, 32'h0);
            chk(rd, {18'h0, w});
            chk_status();
            host.ser_commit();
            {e_test, e_odiv, e_loop} = {32'(w[13:11]), 32'(w[10:9]), 32'(w[8:0])};
            chk_status();
            repeat (4) @(posedge hclk);
            chk({31'h0, probe_out}, k ? 32'h0 : 32'h1);
        end
        // bypass: only the shift clock moves the dividers, the vco is ignored
        w = {synth_cfg_pkg::TEST_BYPASS, synth_cfg_pkg::ODIV_SEL_1, 9'h0C8};
        host.ser_load(w);
        host.ser_commit();
        n_synth = 0;
        repeat (200) @(posedge hclk);
        chk(n_synth, 32'h0);
        host.ser_load(w);
        chk_near(n_synth, 14);
        // parallel strobe low overrides a serial commit and clears the test code
        host.par_set(9'h100, 2'h1);
        host.ser_commit();
        {e_loop, e_odiv, e_test, e_par} = {32'h100, 32'h1, 32'h0, 32'h0};
        chk_status();
        chk({31'h0, probe_out}, {31'h0, w[13]});
        for (int c = 0; c < 4; c++) begin
            host.par_set(9'd200, c[1:0]);
            host.par_commit();
            n_synth = 0;
            repeat (512) @(posedge hclk);
            chk_near(n_synth, c == 0 ? 32 : c == 1 ? 16 : c == 2 ? 8 : 64);
        end
        n_loop = 0;
        n_ref  = 0;
        repeat (4800) @(posedge hclk);
        chk_near(n_loop, 3);
        chk_near(n_ref, 4800 * 10 / (70 * synth_cfg_pkg::REF_PREDIV));
        chk({31'h0, synth_out_n}, {31'h0, ~synth_out});
        // probe codes on steady sources: ref 7 cycles, synth 16, quarter 64, loop 1600
        for (int j = 0; j < 4; j++) begin
            w = {j == 0 ? synth_cfg_pkg::TEST_REF : j == 1 ? synth_cfg_pkg::TEST_SYNTH
                 : j == 2 ? synth_cfg_pkg::TEST_QUART : synth_cfg_pkg::TEST_LOOP,
                 synth_cfg_pkg::ODIV_SEL_2, 9'h0C8};
            host.ser_load(w);
            host.ser_commit();
            n_probe = 0;
            repeat (1680) @(posedge hclk);
            chk_near(n_probe, j == 0 ? 240 : j == 1 ? 105 : j == 2 ? 26 : 1);
        end
        // enable low freezes every flop, so the output stops as well
        ce <= 1'b0;
        @(posedge hclk);
        n_synth = 0;
        repeat (200) @(posedge hclk);
        chk(n_synth, 32'h0);
        ce <= 1'b1;
        @(posedge hclk);
        // run cleared holds the dividers, so the output must stop
        ahb(1'b1, synth_cfg_pkg::REG_CTRL, 32'h0);
        ahb(1'b0, synth_cfg_pkg::REG_CTRL, 32'h0);
        chk(rd, 32'h0);
        n_synth = 0;
        repeat (200) @(posedge hclk);
        chk(n_synth, 32'h0);
        tally_and_finish();
    end
endmodule : synth_divider_config_port_bench
